// File: pkg/txdl_consts.svh
// Offsets, field positions, reset values and sizes of the transmit data-link controller.
`ifndef TXDL_CONSTS_SVH
`define TXDL_CONSTS_SVH

`define TXDL_ADDR_W 12
`define TXDL_ADDR_BUF_COUNT 12'h100
`define TXDL_ADDR_CONTROL 12'h101
`define TXDL_ADDR_IRQ_STATUS 12'h102
`define TXDL_ADDR_IRQ_MASK 12'h103
`define TXDL_BUF0_PAGE 4'h6
`define TXDL_BUF1_PAGE 4'h7
`define TXDL_BUF_DEPTH 128
`define TXDL_BC_SEL_BIT 7
`define TXDL_CTL_MODE_BIT 0
`define TXDL_CTL_FCS_BIT 1
`define TXDL_IRQ_EOT_BIT 0
`define TXDL_IRQ_FREE_BIT 1
`define TXDL_COUNT_RESET 7'h00
`define TXDL_CONTROL_RESET 2'h0
`define TXDL_BOS_LEN 7'h02
`define TXDL_CRC_INIT 16'hFFFF
`define TXDL_CRC_POLY 16'h8408

`endif

// File: pkg/txdl_pkg.sv
// Types shared by the transmit data-link controller.
`default_nettype none
package txdl_pkg;
    typedef enum logic [3:0] {
        txdl_st_idle = 4'h1,
        txdl_st_data = 4'h2,
        txdl_st_fcs_lo = 4'h4,
        txdl_st_fcs_hi = 4'h8
    } txdl_state_t;
endpackage
`default_nettype wire

// File: core/txdl_fcs.sv
// Byte-wise frame check sequence generator for outbound messages.
`timescale 1ns/1ps
`default_nettype none
`include "txdl_consts.svh"

module txdl_fcs (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_clear,
    input wire logic i_update,
    input wire logic [7:0] i_byte,
    // Check octets that would follow once i_byte is folded in, low octet first
    output logic [15:0] o_fcs_next
);
    logic [15:0] crc_q;
    logic [15:0] crc_d;
    logic [15:0] crc_upd;

    always_comb begin
        crc_upd = crc_q ^ {8'h00, i_byte};
        for (int b = 0; b < 8; b++) begin
            crc_upd = crc_upd[0] ? ((crc_upd >> 1) ^ `TXDL_CRC_POLY) : (crc_upd >> 1);
        end
        o_fcs_next = ~crc_upd;
        crc_d = crc_q;
        if (i_clear) begin
            crc_d = `TXDL_CRC_INIT;
        end else if (i_update) begin
            crc_d = crc_upd;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            crc_q <= `TXDL_CRC_INIT;
        end else begin
            crc_q <= crc_d;
        end
    end
endmodule // txdl_fcs

`default_nettype wire

// File: core/txdl_buffer_count_ctrl.sv
// Transmit data-link buffer selection, repeat/length count and message sender.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "txdl_consts.svh"

module txdl_buffer_count_ctrl (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [`TXDL_ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Data-link octet stream
    output logic [7:0] o_dl_data,
    output logic o_dl_valid,
    input wire logic i_dl_ready,
    // Interrupt
    output logic o_irq
);
    logic rst_meta_q;
    logic rst_n;

    // Asynchronous assert, synchronous release.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    logic [7:0] mem_q [0:1][0:`TXDL_BUF_DEPTH-1];
    logic wr_bc, wr_ctl, wr_stat, wr_mask, wr_mem;
    assign wr_bc = i_wr && (i_addr == `TXDL_ADDR_BUF_COUNT);
    assign wr_ctl = i_wr && (i_addr == `TXDL_ADDR_CONTROL);
    assign wr_stat = i_wr && (i_addr == `TXDL_ADDR_IRQ_STATUS);
    assign wr_mask = i_wr && (i_addr == `TXDL_ADDR_IRQ_MASK);
    assign wr_mem = i_wr && (i_addr[11:8] == `TXDL_BUF0_PAGE || i_addr[11:8] == `TXDL_BUF1_PAGE)
        && (i_addr[7] == 1'b0);

    // Software is trusted to fill only the buffer reported available.
    always_ff @(posedge i_clk) begin
        if (wr_mem) begin
            mem_q[i_addr[8]][i_addr[6:0]] <= i_wdata;
        end
    end

    // Register state.
    logic [6:0] cnt_q, cnt_d;
    logic mode_q, mode_d, fcs_en_q, fcs_en_d;
    logic pend_q, pend_d, pend_buf_q, pend_buf_d;
    logic [1:0] busy_q, busy_d;
    logic next_q, next_d;
    logic [1:0] stat_q, stat_d, mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic avail;

    // Engine state.
    txdl_pkg::txdl_state_t st_q, st_d;
    logic [6:0] idx_q, idx_d, len_q, len_d, rep_q, rep_d, lim_q, lim_d;
    logic buf_q, buf_d, mos_q, mos_d, fcs_on_q, fcs_on_d;
    logic [7:0] fcs_hi_q, fcs_hi_d, ddat_q, ddat_d;
    logic dval_q, dval_d;
    logic pend_clr, done, eot_ev, crc_clr, crc_upd, accept;
    logic [15:0] fcs_next;

    assign accept = dval_q && i_dl_ready;

    txdl_fcs u_fcs (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_clear(crc_clr),
        .i_update(crc_upd),
        .i_byte(ddat_q),
        .o_fcs_next(fcs_next)
    );

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        len_d = len_q;
        rep_d = rep_q;
        lim_d = lim_q;
        buf_d = buf_q;
        mos_d = mos_q;
        fcs_on_d = fcs_on_q;
        fcs_hi_d = fcs_hi_q;
        ddat_d = ddat_q;
        dval_d = dval_q;
        pend_clr = 1'b0;
        done = 1'b0;
        eot_ev = 1'b0;
        crc_clr = 1'b0;
        crc_upd = 1'b0;
        unique case (st_q)
            txdl_pkg::txdl_st_idle: begin
                if (pend_q) begin
                    pend_clr = 1'b1;
                    crc_clr = 1'b1;
                    buf_d = pend_buf_q;
                    mos_d = mode_q;
                    fcs_on_d = fcs_en_q && mode_q;
                    len_d = mode_q ? cnt_q : `TXDL_BOS_LEN;
                    lim_d = cnt_q;
                    rep_d = 7'h00;
                    idx_d = 7'h00;
                    if (len_d == 7'h00) begin
                        done = 1'b1;
                        eot_ev = 1'b1;
                    end else begin
                        st_d = txdl_pkg::txdl_st_data;
                        dval_d = 1'b1;
                        ddat_d = mem_q[pend_buf_q][0];
                    end
                end
            end
            txdl_pkg::txdl_st_data: begin
                if (accept) begin
                    crc_upd = mos_q;
                    if ((idx_q + 7'h01) != len_q) begin
                        idx_d = idx_q + 7'h01;
                        ddat_d = mem_q[buf_q][idx_d];
                    end else if (mos_q) begin
                        if (fcs_on_q) begin
                            st_d = txdl_pkg::txdl_st_fcs_lo;
                            ddat_d = fcs_next[7:0];
                            fcs_hi_d = fcs_next[15:8];
                        end else begin
                            done = 1'b1;
                            eot_ev = 1'b1;
                        end
                    end else begin
                        rep_d = rep_q + 7'h01;
                        if (lim_q != 7'h00 && rep_d == lim_q) begin
                            done = 1'b1;
                            eot_ev = 1'b1;
                        end else if (pend_q && lim_q == 7'h00) begin
                            // A newer message takes over an endless repeat at a boundary.
                            done = 1'b1;
                        end else begin
                            idx_d = 7'h00;
                            ddat_d = mem_q[buf_q][0];
                        end
                    end
                end
            end
            txdl_pkg::txdl_st_fcs_lo: begin
                if (accept) begin
                    st_d = txdl_pkg::txdl_st_fcs_hi;
                    ddat_d = fcs_hi_q;
                end
            end
            txdl_pkg::txdl_st_fcs_hi: begin
                if (accept) begin
                    done = 1'b1;
                    eot_ev = 1'b1;
                end
            end
        endcase
        if (done) begin
            st_d = txdl_pkg::txdl_st_idle;
            dval_d = 1'b0;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= txdl_pkg::txdl_st_idle;
            idx_q <= 7'h00;
            len_q <= 7'h00;
            rep_q <= 7'h00;
            lim_q <= 7'h00;
            buf_q <= 1'b0;
            mos_q <= 1'b0;
            fcs_on_q <= 1'b0;
            fcs_hi_q <= 8'h00;
            ddat_q <= 8'h00;
            dval_q <= 1'b0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            len_q <= len_d;
            rep_q <= rep_d;
            lim_q <= lim_d;
            buf_q <= buf_d;
            mos_q <= mos_d;
            fcs_on_q <= fcs_on_d;
            fcs_hi_q <= fcs_hi_d;
            ddat_q <= ddat_d;
            dval_q <= dval_d;
        end
    end

    always_comb begin
        // Report the free buffer; with both free, alternate from the last one chosen.
        avail = busy_q[0] ? 1'b1 : (busy_q[1] ? 1'b0 : next_q);
        cnt_d = wr_bc ? i_wdata[6:0] : cnt_q;
        mode_d = wr_ctl ? i_wdata[`TXDL_CTL_MODE_BIT] : mode_q;
        fcs_en_d = wr_ctl ? i_wdata[`TXDL_CTL_FCS_BIT] : fcs_en_q;
        pend_d = wr_bc ? 1'b1 : (pend_clr ? 1'b0 : pend_q);
        pend_buf_d = wr_bc ? i_wdata[`TXDL_BC_SEL_BIT] : pend_buf_q;
        next_d = wr_bc ? ~i_wdata[`TXDL_BC_SEL_BIT] : next_q;
        busy_d = busy_q;
        if (done) begin
            // An empty message ends in idle, before buf_q has taken the new buffer.
            busy_d[buf_d] = 1'b0;
        end
        if (wr_bc) begin
            busy_d[i_wdata[`TXDL_BC_SEL_BIT]] = 1'b1;
        end
        // A new event wins over a write-one clear in the same cycle.
        stat_d = stat_q & ~(wr_stat ? i_wdata[1:0] : 2'h0);
        stat_d[`TXDL_IRQ_EOT_BIT] = stat_d[`TXDL_IRQ_EOT_BIT] | eot_ev;
        stat_d[`TXDL_IRQ_FREE_BIT] = stat_d[`TXDL_IRQ_FREE_BIT] | done;
        mask_d = wr_mask ? i_wdata[1:0] : mask_q;
        irq_d = |(stat_d & mask_d);
        rdata_d = 8'h00;
        if (i_rd) begin
            if (i_addr == `TXDL_ADDR_BUF_COUNT) begin
                rdata_d = {avail, cnt_q};
            end else if (i_addr == `TXDL_ADDR_CONTROL) begin
                rdata_d = {6'h00, fcs_en_q, mode_q};
            end else if (i_addr == `TXDL_ADDR_IRQ_STATUS) begin
                rdata_d = {6'h00, stat_q};
            end else if (i_addr == `TXDL_ADDR_IRQ_MASK) begin
                rdata_d = {6'h00, mask_q};
            end else if ((i_addr[11:8] == `TXDL_BUF0_PAGE || i_addr[11:8] == `TXDL_BUF1_PAGE)
                && i_addr[7] == 1'b0) begin
                rdata_d = mem_q[i_addr[8]][i_addr[6:0]];
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `TXDL_COUNT_RESET;
            mode_q <= 1'b0;
            fcs_en_q <= 1'b0;
            pend_q <= 1'b0;
            pend_buf_q <= 1'b0;
            busy_q <= 2'h0;
            next_q <= 1'b0;
            stat_q <= 2'h0;
            mask_q <= 2'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            mode_q <= mode_d;
            fcs_en_q <= fcs_en_d;
            pend_q <= pend_d;
            pend_buf_q <= pend_buf_d;
            busy_q <= busy_d;
            next_q <= next_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_dl_data = ddat_q;
    assign o_dl_valid = dval_q;
    assign o_irq = irq_q;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!rst_n);
    property p_sel_busy;
        wr_bc |=> busy_q[$past(i_wdata[7])] && pend_buf_q == $past(i_wdata[7]);
    endproperty
    a_sel_busy: assert property (p_sel_busy) else $error("selected buffer not marked busy");
    property p_avail_read;
        i_rd && i_addr == `TXDL_ADDR_BUF_COUNT && busy_q == 2'b01 && !wr_bc && !done
            |=> o_rdata[7] == 1'b1;
    endproperty
    a_avail_read: assert property (p_avail_read) else $error("buffer one not reported free");
    property p_avail_other;
        busy_q == 2'b10 |-> avail == 1'b0;
    endproperty
    a_avail_other: assert property (p_avail_other) else $error("buffer zero not reported free");
    property p_bos_end;
        st_q == txdl_pkg::txdl_st_data && accept && !mos_q && lim_q != 7'h00
            && (idx_q + 7'h01) == len_q && (rep_q + 7'h01) == lim_q
            |=> st_q == txdl_pkg::txdl_st_idle && stat_q[0] && !o_dl_valid;
    endproperty
    a_bos_end: assert property (p_bos_end) else $error("count-limited repeat did not end");
    property p_bos_forever;
        st_q == txdl_pkg::txdl_st_data && accept && !mos_q && lim_q == 7'h00 && !pend_q
            && (idx_q + 7'h01) == len_q
            |=> st_q == txdl_pkg::txdl_st_data && idx_q == 7'h00 && o_dl_valid;
    endproperty
    a_bos_forever: assert property (p_bos_forever) else $error("zero count stopped repeating");
    property p_mos_len;
        st_q == txdl_pkg::txdl_st_data && accept && mos_q && !fcs_on_q
            && (idx_q + 7'h01) == len_q
            |=> st_q == txdl_pkg::txdl_st_idle && !o_dl_valid && stat_q[0];
    endproperty
    a_mos_len: assert property (p_mos_len) else $error("message length not honoured");
    property p_mode_latch;
        st_q == txdl_pkg::txdl_st_idle && pend_q |=> mos_q == $past(mode_q);
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not taken at start");
    property p_fcs_two;
        st_q == txdl_pkg::txdl_st_data && accept && mos_q && fcs_on_q
            && (idx_q + 7'h01) == len_q
            |=> st_q == txdl_pkg::txdl_st_fcs_lo && o_dl_valid;
    endproperty
    a_fcs_two: assert property (p_fcs_two) else $error("check octets not appended");
    property p_free;
        done && !(wr_bc && i_wdata[7] == buf_d) |=> !busy_q[$past(buf_d)];
    endproperty
    a_free: assert property (p_free) else $error("finished buffer still busy");
    property p_hold;
        o_dl_valid && !i_dl_ready |=> o_dl_valid && $stable(o_dl_data);
    endproperty
    a_hold: assert property (p_hold) else $error("octet dropped while stalled");
    c_bos_end: cover property (p_bos_end);
    c_fcs: cover property (st_q == txdl_pkg::txdl_st_fcs_hi && accept);
    c_irq: cover property (o_irq);
endmodule // txdl_buffer_count_ctrl

`default_nettype wire

// File: verification/txdl_link_sink.sv
// Remote terminal model that takes outbound data-link octets, promptly or with stalls.
`timescale 1ns/1ps
`default_nettype none

module txdl_link_sink (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Data-link octet stream
    input wire logic [7:0] i_data,
    input wire logic i_valid,
    output logic o_ready,
    // Pacing
    input wire logic i_stall
);
    logic [7:0] got[$];
    logic [1:0] phase_q;

    // When stalling, the link takes one octet in four cycles at most.
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_ready <= 1'b0;
            phase_q <= 2'h0;
        end else begin
            if (i_valid && o_ready) begin
                got.push_back(i_data);
            end
            phase_q <= phase_q + 2'h1;
            o_ready <= !i_stall || (phase_q == 2'h2);
        end
    end
endmodule // txdl_link_sink

`default_nettype wire

// File: verification/test_tx_datalink_buffer_count_ctrl.sv
// Register-level testbench of the transmit data-link buffer and count controller.
`timescale 1ns/1ps
`default_nettype none
`include "txdl_consts.svh"

module test_tx_datalink_buffer_count_ctrl;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic stall = 1'b0;
    logic [11:0] i_addr = 12'h000;
    logic [7:0] i_wdata = 8'h00;
    logic [7:0] o_rdata;
    logic [7:0] o_dl_data;
    logic o_dl_valid;
    logic dl_ready;
    logic o_irq;
    int err_total = 0;
    int check_count = 0;
    logic [7:0] v;
    logic [7:0] exp_q[$];
    logic [15:0] crc;
    logic [6:0] cnt_tab[3] = '{7'h03, 7'h01, 7'h00};
    logic [7:0] ctl_tab[3] = '{8'h03, 8'h01, 8'h03};
    localparam logic [11:0] BC = `TXDL_ADDR_BUF_COUNT;
    localparam logic [11:0] CTL = `TXDL_ADDR_CONTROL;
    localparam logic [11:0] STS = `TXDL_ADDR_IRQ_STATUS;
    localparam logic [11:0] MSK = `TXDL_ADDR_IRQ_MASK;
    localparam logic [11:0] B0 = {`TXDL_BUF0_PAGE, 8'h00};
    localparam logic [11:0] B1 = {`TXDL_BUF1_PAGE, 8'h00};

    always #50 i_clk = ~i_clk;

    txdl_buffer_count_ctrl dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_dl_data(o_dl_data),
        .o_dl_valid(o_dl_valid), .i_dl_ready(dl_ready), .o_irq(o_irq)
    );

    txdl_link_sink sink (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_data(o_dl_data), .i_valid(o_dl_valid),
        .o_ready(dl_ready), .i_stall(stall)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic wait_eot();
        int n;
        n = 0;
        v = 8'h00;
        while (v[0] !== 1'b1 && n < 300) begin
            rd(STS, v);
            n++;
        end
        chk(v[0], 1'b1, "end of transfer");
    endtask

    task automatic check_rx(input string what);
        chk(16'(sink.got.size()), 16'(exp_q.size()), what);
        foreach (exp_q[i]) begin
            if (i < sink.got.size()) begin
                chk(sink.got[i], exp_q[i], what);
            end
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        #3000000;
        err_total++;
        $display("BAD %0t watchdog expired", $time);
        complete_run();
    end

    initial begin
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_clk);
        for (int a = 0; a < 4; a++) begin
            rd(BC + 12'(a), v);
            chk(v, 8'h00, "reset value");
        end
        wr(12'h1FF, 8'hFF);
        rd(12'h1FF, v);
        chk(v, 8'h00, "unmapped read");
        chk(o_irq, 1'b0, "irq after reset");
        for (int i = 0; i < 4; i++) begin
            wr(B0 + 12'(i), 8'h10 + 8'(i));
            wr(B1 + 12'(i), 8'hA0 + 8'(i));
        end
        rd(B1 + 12'h002, v);
        chk(v, 8'hA2, "buffer readback");
        $display("test reset and access done");

        // Two repetitions of buffer one in bit-oriented mode, interrupt masked at first.
        wr(CTL, 8'h00);
        wr(BC, 8'h82);
        rd(BC, v);
        chk(v[7], 1'b0, "free buffer while one busy");
        wait_eot();
        exp_q = '{8'hA0, 8'hA1, 8'hA0, 8'hA1};
        check_rx("bit-oriented repeats");
        rd(STS, v);
        chk(v, 8'h03, "status after message");
        chk(o_irq, 1'b0, "masked irq");
        wr(MSK, 8'h01);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b1, "unmasked irq");
        wr(STS, 8'h03);
        repeat (3) @(posedge i_clk);
        chk(o_irq, 1'b0, "irq after clear");
        rd(STS, v);
        chk(v, 8'h00, "status after clear");
        rd(BC, v);
        chk(v, 8'h02, "next buffer after bit-oriented");
        $display("test bit-oriented count done");

        // Message-oriented lengths with and without check octets; the first run stalls the link.
        for (int k = 0; k < 3; k++) begin
            sink.got.delete();
            exp_q.delete();
            stall <= (k == 0);
            wr(CTL, ctl_tab[k]);
            wr(BC, {1'b0, cnt_tab[k]});
            if (k == 0) begin
                rd(BC, v);
                chk(v[7], 1'b1, "free buffer while zero busy");
            end
            crc = `TXDL_CRC_INIT;
            for (int i = 0; i < int'(cnt_tab[k]); i++) begin
                exp_q.push_back(8'h10 + 8'(i));
                crc = crc ^ {8'h00, 8'h10 + 8'(i)};
                repeat (8) crc = crc[0] ? ((crc >> 1) ^ `TXDL_CRC_POLY) : (crc >> 1);
            end
            crc = ~crc;
            if (ctl_tab[k][1] && cnt_tab[k] != 7'h00) begin
                exp_q.push_back(crc[7:0]);
                exp_q.push_back(crc[15:8]);
            end
            wait_eot();
            check_rx("message-oriented octets");
            wr(STS, 8'h03);
        end
        stall <= 1'b0;
        rd(BC, v);
        chk(v, 8'h80, "next buffer after message-oriented");
        $display("test message-oriented length done");

        // A zero count repeats forever until a new start replaces it at a boundary.
        sink.got.delete();
        wr(CTL, 8'h00);
        wr(BC, 8'h00);
        repeat (40) @(posedge i_clk);
        rd(STS, v);
        chk(v[0], 1'b0, "no end while endless");
        chk(sink.got.size() > 8, 1'b1, "endless keeps sending");
        wr(BC, 8'h81);
        wait_eot();
        v = 8'(sink.got.size());
        chk(sink.got[v - 8'h01], 8'hA1, "last octet after preempt");
        chk(sink.got[v - 8'h02], 8'hA0, "first octet after preempt");
        chk(sink.got[v - 8'h03], 8'h11, "boundary before preempt");
        $display("test endless repeat done");
        complete_run();
    end
endmodule // test_tx_datalink_buffer_count_ctrl

`default_nettype wire
